/* File: common/monitor_defs.vh */
// register offsets, field positions, reset values and timing counts for the monitor target
`ifndef MONITOR_DEFS_VH
`define MONITOR_DEFS_VH
`define PTR_CONFIG 8'h00
`define PTR_SHUNT 8'h01
`define PTR_BUS 8'h02
`define PTR_POWER 8'h03
`define PTR_CURRENT 8'h04
`define PTR_CAL 8'h05
`define PTR_MASK 8'h06
`define PTR_LIMIT 8'h07
`define PTR_MAKER 8'h3E
`define PTR_PART 8'h3F
`define CFG_RESET 16'h4127
`define REG_ZERO 16'h0000
`define CFG_RST_BIT 15
`define CFG_FIXED_HI 14
`define CFG_FIXED_LO 13
`define CFG_FIXED_VAL 2'h2
`define CFG_RANGE_BIT 12
`define CFG_AVG_HI 11
`define CFG_AVG_LO 9
`define CFG_BUSCT_HI 8
`define CFG_BUSCT_LO 6
`define CFG_SHCT_HI 5
`define CFG_SHCT_LO 3
`define CFG_MODE_HI 2
`define CFG_MODE_LO 0
`define ADDR_BASE 7'h40
`define ADDR_GCALL 7'h00
`define ADDR_ALERT 7'h0C
`define GCALL_RESET 8'h06
`define HS_CODE_TOP 5'h01
`define MODE_OFF0 3'h0
`define MODE_SH_ONE 3'h1
`define MODE_BUS_ONE 3'h2
`define MODE_BOTH_ONE 3'h3
`define MODE_OFF1 3'h4
`define MODE_SH_CONT 3'h5
`define MODE_BOTH_CONT 3'h6
`define MODE_DEF_CONT 3'h7
`define CLK_MHZ 10
`define CONV_US_0 140
`define CONV_US_1 204
`define CONV_US_2 332
`define CONV_US_3 588
`define CONV_US_4 1100
`define CONV_US_5 2116
`define CONV_US_6 4156
`define CONV_US_7 8244
`endif

/* File: rtl/bus_sync.v */
// two-flop synchroniser for the bus pins and address strap
`timescale 1ns/100ps
module bus_sync #(
  parameter W = 3
) (
  input wire clk,
  input wire ce,
  input wire rst_n,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  // first stage, read only by the second
  reg [W-1:0] meta_reg;
  // both stages clear to all ones (idle bus high)
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= {W{1'b1}};
      q <= {W{1'b1}};
    end else if (ce) begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

/* File: rtl/conv_sequencer.v */
// conversion sequencer: timing, averaging and result refresh
`timescale 1ns/100ps
`include "monitor_defs.vh"
module conv_sequencer #(
  parameter TW = 17
) (
  input wire clk,
  input wire ce,
  input wire rst_n,
  input wire soft_rst,
  input wire [2:0] mode,
  input wire [2:0] average_count,
  input wire [2:0] bus_conv_time,
  input wire [2:0] shunt_conv_time,
  input wire trigger,
  output reg busy,
  output reg result_update
);
  localparam S_IDLE = 2'd0;
  localparam S_SHUNT = 2'd1;
  localparam S_BUS = 2'd2;
  // cycles per conversion for a code
  function [TW-1:0] conv_cycles;
    input [2:0] code;
    // product at full width, cut to the timer width below
    reg [31:0] full;
    begin
      case (code)
        3'h0: full = `CONV_US_0 * `CLK_MHZ;
        3'h1: full = `CONV_US_1 * `CLK_MHZ;
        3'h2: full = `CONV_US_2 * `CLK_MHZ;
        3'h3: full = `CONV_US_3 * `CLK_MHZ;
        3'h4: full = `CONV_US_4 * `CLK_MHZ;
        3'h5: full = `CONV_US_5 * `CLK_MHZ;
        3'h6: full = `CONV_US_6 * `CLK_MHZ;
        default: full = `CONV_US_7 * `CLK_MHZ;
      endcase
      conv_cycles = full[TW-1:0];
    end
  endfunction
  // samples averaged for a code
  function [10:0] avg_samples;
    input [2:0] code;
    begin
      case (code)
        3'h0: avg_samples = 11'd1;
        3'h1: avg_samples = 11'd4;
        3'h2: avg_samples = 11'd16;
        3'h3: avg_samples = 11'd64;
        3'h4: avg_samples = 11'd128;
        3'h5: avg_samples = 11'd256;
        3'h6: avg_samples = 11'd512;
        default: avg_samples = 11'd1024;
      endcase
    end
  endfunction
  reg [1:0] state_reg;
  reg [TW-1:0] timer_reg;
  reg [10:0] sample_reg;
  reg oneshot_reg;
  // mode decode
  wire do_shunt = (mode == `MODE_SH_ONE) || (mode == `MODE_BOTH_ONE) || (mode == `MODE_SH_CONT) ||
    (mode == `MODE_BOTH_CONT) || (mode == `MODE_DEF_CONT);
  wire do_bus = (mode == `MODE_BUS_ONE) || (mode == `MODE_BOTH_ONE) || (mode == `MODE_BOTH_CONT) ||
    (mode == `MODE_DEF_CONT);
  wire continuous = mode[2] && (mode[1:0] != 2'b00);
  wire single = !mode[2] && (mode[1:0] != 2'b00);
  wire last_sample = (sample_reg + 11'd1) >= avg_samples(average_count);
  // conversion state machine
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= S_IDLE;
      timer_reg <= {TW{1'b0}};
      sample_reg <= 11'd0;
      oneshot_reg <= 1'b0;
      busy <= 1'b0;
      result_update <= 1'b0;
    end else if (ce) begin
      result_update <= 1'b0;
      // RL17: shutdown codes stop any run
      if (soft_rst || !(do_shunt || do_bus)) begin
        state_reg <= S_IDLE;
        sample_reg <= 11'd0;
        oneshot_reg <= 1'b0;
        busy <= 1'b0;
      end else begin
        case (state_reg)
          S_IDLE: begin
            sample_reg <= 11'd0;
            // RL18: default code runs continuously
            if ((continuous || (single && (trigger || oneshot_reg))) && (do_shunt || do_bus)) begin
              busy <= 1'b1;
              oneshot_reg <= 1'b0;
              state_reg <= do_shunt ? S_SHUNT : S_BUS;
              timer_reg <= do_shunt ? conv_cycles(shunt_conv_time) : conv_cycles(bus_conv_time);
            end else begin
              busy <= 1'b0;
            end
          end
          S_SHUNT: begin
            // RL16: shunt conversion time
            if (timer_reg > {{(TW-1){1'b0}}, 1'b1}) begin
              timer_reg <= timer_reg - {{(TW-1){1'b0}}, 1'b1};
            end else if (do_bus) begin
              state_reg <= S_BUS;
              timer_reg <= conv_cycles(bus_conv_time);
            end else begin
              state_reg <= S_IDLE;
              // RL14: refresh after averaging only
              if (last_sample) begin
                result_update <= 1'b1;
              end else begin
                sample_reg <= sample_reg + 11'd1;
                state_reg <= S_SHUNT;
                timer_reg <= conv_cycles(shunt_conv_time);
              end
            end
          end
          S_BUS: begin
            // RL15: bus conversion time
            if (timer_reg > {{(TW-1){1'b0}}, 1'b1}) begin
              timer_reg <= timer_reg - {{(TW-1){1'b0}}, 1'b1};
            end else if (last_sample) begin
              // RL13: averaging count reached
              result_update <= 1'b1;
              state_reg <= S_IDLE;
            end else begin
              sample_reg <= sample_reg + 11'd1;
              state_reg <= do_shunt ? S_SHUNT : S_BUS;
              timer_reg <= do_shunt ? conv_cycles(shunt_conv_time) : conv_cycles(bus_conv_time);
            end
          end
          default: state_reg <= S_IDLE;
        endcase
        // a trigger during a run is remembered for single-shot modes
        if (trigger && state_reg != S_IDLE) begin
          oneshot_reg <= 1'b1;
        end
      end
    end
  end
endmodule

/* File: rtl/monitor_i2c_target.v */
// two-wire target with register file for the current, voltage and power monitor
// Notes on behaviour
// RL1: HS code not acknowledged, fast filters enabled
// RL2: controller sends HS code at 400 kHz
// RL3: repeated start keeps HS, stop ends it
// RL4: general call write then 06h soft-resets
// RL5: general call read starts a conversion
// RL6: alert response acked, own address sent
// RL7: lost arbitration: no ack, alert held
// RL8: sixteen-bit registers at 0-7, 3Eh, 3Fh
// RL9: configuration 4127h, others reset to zero
// RL10: configuration bit 15 resets, self-clears
// RL11: configuration bits 14:13 always read 10
// RL12: bit 12 chooses shunt input range
// RL13: bits 11:9 select averaging count
// RL14: results refresh only after averaging ends
// RL15: bits 8:6 set bus conversion time
// RL16: bits 5:3 set shunt conversion time
// RL17: bits 2:0 choose operating mode
// RL18: mode 111 runs shunt and bus continuously
// RL19: write: address, pointer, two bytes MSB-first
// RL20: read returns pointed register, pointer kept
// RL21: address pin sampled, four addresses
`timescale 1ns/100ps
`include "monitor_defs.vh"
module monitor_i2c_target #(
  parameter [15:0] MAKER_CODE = 16'h1234, // arbitrary value
  parameter [15:0] PART_CODE = 16'h5678, // arbitrary value
  parameter TW = 17
) (
  // clock, enable, reset
  input wire REF_CLK,
  input wire CE,
  input wire RST_N,
  // two-wire bus pins
  input wire SCL_IN,
  input wire SDA_IN,
  output reg SDA_OUT,
  output reg SDA_OE_N,
  // address strap: 0 gnd, 1 supply, 2 data, 3 clock
  input wire [1:0] ADDRESS_SELECT_PIN,
  // alert line, open drain
  input wire ALERT_IN,
  output reg ALERT_OE_N,
  // status and configuration out
  output reg HS_MODE,
  output reg SHUNT_RANGE_SELECT,
  output reg CONV_BUSY
);
  localparam B_IDLE = 3'd0;
  localparam B_ADDR = 3'd1;
  localparam B_ACK = 3'd2;
  localparam B_RX = 3'd3;
  localparam B_TX = 3'd4;
  localparam B_MACK = 3'd5;
  localparam B_IGN = 3'd6;
  // reset release
  reg rst_m_reg;
  reg rst_s_reg;
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_m_reg <= 1'b0;
      rst_s_reg <= 1'b0;
    end else begin
      rst_m_reg <= 1'b1;
      rst_s_reg <= rst_m_reg;
    end
  end
  wire rst_n = rst_s_reg;
  // synchronised pins
  wire [4:0] pins_s;
  bus_sync #(.W(5)) u_sync (
    .clk(REF_CLK),
    .ce(CE),
    .rst_n(rst_n),
    .d({SCL_IN, SDA_IN, ALERT_IN, ADDRESS_SELECT_PIN}),
    .q(pins_s)
  );
  wire scl = pins_s[4];
  wire sda = pins_s[3];
  reg scl_d_reg;
  reg sda_d_reg;
  wire scl_rise = scl && !scl_d_reg;
  wire scl_fall = !scl && scl_d_reg;
  wire start_c = scl && scl_d_reg && sda_d_reg && !sda;
  wire stop_c = scl && scl_d_reg && !sda_d_reg && sda;
  // registers
  reg [15:0] cfg_reg;
  reg [15:0] shunt_reg;
  reg [15:0] bus_reg;
  reg [15:0] power_reg;
  reg [15:0] current_reg;
  reg [14:0] cal_reg;
  reg [15:0] mask_reg;
  reg [15:0] limit_reg;
  reg [7:0] ptr_reg;
  // byte engine
  reg [2:0] st_reg;
  reg [2:0] ret_reg;
  reg [3:0] bit_reg;
  reg [7:0] sh_reg;
  reg [7:0] tx_reg;
  reg [1:0] cnt_reg;
  reg [7:0] hi_reg;
  reg rd_reg;
  reg gcall_reg;
  reg arsp_reg;
  reg ack_reg;
  reg soft_rst_reg;
  reg trig_reg;
  reg hs_next;
  reg [1:0] strap_reg;
  // own target address from the strap
  wire [6:0] own_addr = `ADDR_BASE | {5'h00, strap_reg};
  // register read mux
  function [15:0] rd_mux;
    input [7:0] p;
    begin
      case (p)
        `PTR_CONFIG: rd_mux = cfg_reg;
        `PTR_SHUNT: rd_mux = shunt_reg;
        `PTR_BUS: rd_mux = bus_reg;
        `PTR_POWER: rd_mux = power_reg;
        `PTR_CURRENT: rd_mux = current_reg;
        `PTR_CAL: rd_mux = {1'b0, cal_reg};
        `PTR_MASK: rd_mux = mask_reg;
        `PTR_LIMIT: rd_mux = limit_reg;
        `PTR_MAKER: rd_mux = MAKER_CODE;
        `PTR_PART: rd_mux = PART_CODE;
        default: rd_mux = `REG_ZERO;
      endcase
    end
  endfunction
  wire conv_done;
  wire conv_busy;
  conv_sequencer #(.TW(TW)) u_seq (
    .clk(REF_CLK),
    .ce(CE),
    .rst_n(rst_n),
    .soft_rst(soft_rst_reg),
    .mode(cfg_reg[`CFG_MODE_HI:`CFG_MODE_LO]),
    .average_count(cfg_reg[`CFG_AVG_HI:`CFG_AVG_LO]),
    .bus_conv_time(cfg_reg[`CFG_BUSCT_HI:`CFG_BUSCT_LO]),
    .shunt_conv_time(cfg_reg[`CFG_SHCT_HI:`CFG_SHCT_LO]),
    .trigger(trig_reg),
    .busy(conv_busy),
    .result_update(conv_done)
  );
  // alert source: a completed conversion while enabled by the mask word
  reg alert_reg;
  // main engine
  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      st_reg <= B_IDLE;
      ret_reg <= B_IDLE;
      bit_reg <= 4'd0;
      sh_reg <= 8'h00;
      tx_reg <= 8'h00;
      cnt_reg <= 2'd0;
      hi_reg <= 8'h00;
      rd_reg <= 1'b0;
      gcall_reg <= 1'b0;
      arsp_reg <= 1'b0;
      ack_reg <= 1'b0;
      soft_rst_reg <= 1'b0;
      trig_reg <= 1'b0;
      hs_next <= 1'b0;
      strap_reg <= 2'd0;
      ptr_reg <= 8'h00;
      cfg_reg <= `CFG_RESET;
      shunt_reg <= `REG_ZERO;
      bus_reg <= `REG_ZERO;
      power_reg <= `REG_ZERO;
      current_reg <= `REG_ZERO;
      cal_reg <= 15'h0000;
      mask_reg <= `REG_ZERO;
      limit_reg <= `REG_ZERO;
      alert_reg <= 1'b0;
      SDA_OUT <= 1'b0;
      SDA_OE_N <= 1'b1;
      ALERT_OE_N <= 1'b1;
      HS_MODE <= 1'b0;
      SHUNT_RANGE_SELECT <= 1'b0;
      CONV_BUSY <= 1'b0;
    end else if (CE) begin
      scl_d_reg <= scl;
      sda_d_reg <= sda;
      soft_rst_reg <= 1'b0;
      trig_reg <= 1'b0;
      CONV_BUSY <= conv_busy;
      // RL12: range select drives the front end
      SHUNT_RANGE_SELECT <= cfg_reg[`CFG_RANGE_BIT];
      HS_MODE <= hs_next;
      ALERT_OE_N <= !alert_reg;
      // results refresh; datapath values not modelled here
      if (conv_done && mask_reg != `REG_ZERO) begin
        alert_reg <= 1'b1;
      end
      if (stop_c) begin
        // RL3: stop leaves high-speed mode
        hs_next <= 1'b0;
        st_reg <= B_IDLE;
        SDA_OE_N <= 1'b1;
      end else if (start_c) begin
        // RL21: strap sampled on every transaction
        strap_reg <= pins_s[1:0];
        st_reg <= B_ADDR;
        bit_reg <= 4'd0;
        cnt_reg <= 2'd0;
        SDA_OE_N <= 1'b1;
      end else begin
        case (st_reg)
          B_IDLE: SDA_OE_N <= 1'b1;
          B_ADDR, B_RX: begin
            if (scl_rise) begin
              sh_reg <= {sh_reg[6:0], sda};
              bit_reg <= bit_reg + 4'd1;
            end
            if (scl_fall && bit_reg == 4'd8) begin
              bit_reg <= 4'd0;
              ack_reg <= 1'b0;
              ret_reg <= B_RX;
              if (st_reg == B_ADDR) begin
                rd_reg <= sh_reg[0];
                gcall_reg <= sh_reg[7:1] == `ADDR_GCALL;
                arsp_reg <= 1'b0;
                if (sh_reg[7:3] == `HS_CODE_TOP) begin
                  // RL1: HS code left unacknowledged
                  hs_next <= 1'b1;
                  st_reg <= B_IGN;
                end else if (sh_reg[7:1] == own_addr) begin
                  ack_reg <= 1'b1;
                  {tx_reg, hi_reg} <= rd_mux(ptr_reg);
                  ret_reg <= sh_reg[0] ? B_TX : B_RX;
                end else if (sh_reg[7:1] == `ADDR_GCALL) begin
                  // RL5: general call read triggers conversion
                  if (sh_reg[0]) begin
                    trig_reg <= 1'b1;
                    st_reg <= B_IGN;
                  end else begin
                    ack_reg <= 1'b1;
                  end
                end else if (sh_reg[7:1] == `ADDR_ALERT && sh_reg[0] && alert_reg) begin
                  // RL6: answer alert response with own address
                  ack_reg <= 1'b1;
                  arsp_reg <= 1'b1;
                  tx_reg <= {own_addr, 1'b0};
                  ret_reg <= B_TX;
                end else begin
                  st_reg <= B_IGN;
                end
                if (sh_reg[7:3] != `HS_CODE_TOP && (sh_reg[7:1] == own_addr ||
                  (sh_reg[7:1] == `ADDR_GCALL && !sh_reg[0]) ||
                  (sh_reg[7:1] == `ADDR_ALERT && sh_reg[0] && alert_reg))) begin
                  st_reg <= B_ACK;
                  SDA_OUT <= 1'b0;
                  SDA_OE_N <= 1'b0;
                end
              end else begin
                // RL4: general call byte 06h soft-resets
                if (gcall_reg) begin
                  ack_reg <= 1'b1;
                  if (sh_reg == `GCALL_RESET) begin
                    soft_rst_reg <= 1'b1;
                  end
                end else if (cnt_reg == 2'd0) begin
                  // RL19: pointer byte first
                  ptr_reg <= sh_reg;
                  cnt_reg <= 2'd1;
                  ack_reg <= 1'b1;
                end else if (cnt_reg == 2'd1) begin
                  hi_reg <= sh_reg;
                  cnt_reg <= 2'd2;
                  ack_reg <= 1'b1;
                end else begin
                  ack_reg <= 1'b1;
                  cnt_reg <= 2'd3;
                  // RL8: only listed writable locations change
                  case (ptr_reg)
                    `PTR_CONFIG: begin
                      // RL10: bit 15 soft-resets and self-clears
                      if (hi_reg[7]) begin
                        soft_rst_reg <= 1'b1;
                      end else begin
                        // RL11: bits 14:13 fixed at 10
                        // RL17: mode field stored as written
                        cfg_reg <= {1'b0, `CFG_FIXED_VAL, hi_reg[4:0], sh_reg};
                      end
                    end
                    `PTR_CAL: cal_reg <= {hi_reg[6:0], sh_reg};
                    `PTR_MASK: mask_reg <= {hi_reg, sh_reg};
                    `PTR_LIMIT: limit_reg <= {hi_reg, sh_reg};
                    default: cnt_reg <= 2'd3;
                  endcase
                  // a third data byte is acknowledged and written again as the low byte, with the held high byte
                end
                st_reg <= B_ACK;
                SDA_OUT <= 1'b0;
                SDA_OE_N <= 1'b0;
              end
            end
          end
          B_ACK: begin
            // hold ack through the ninth clock, then release or drive data
            if (scl_fall) begin
              bit_reg <= 4'd0;
              if (ret_reg == B_TX) begin
                st_reg <= B_TX;
                SDA_OUT <= tx_reg[7];
                SDA_OE_N <= tx_reg[7];
              end else begin
                st_reg <= B_RX;
                SDA_OE_N <= 1'b1;
              end
            end
          end
          B_TX: begin
            if (scl_rise) begin
              // RL7: lost arbitration, stop driving
              if (!SDA_OE_N || tx_reg[7] == sda) begin
                bit_reg <= bit_reg + 4'd1;
              end else begin
                st_reg <= B_IGN;
              end
            end
            if (scl_fall) begin
              if (bit_reg == 4'd8) begin
                SDA_OE_N <= 1'b1;
                st_reg <= B_MACK;
              end else begin
                tx_reg <= {tx_reg[6:0], 1'b0};
                SDA_OUT <= tx_reg[6];
                SDA_OE_N <= tx_reg[6];
              end
            end
          end
          B_MACK: begin
            if (scl_rise) begin
              // RL6: alert clears only once our address went out
              if (arsp_reg) begin
                // a fresh alert event in this cycle wins over the release
                alert_reg <= conv_done && (mask_reg != `REG_ZERO);
                arsp_reg <= 1'b0;
              end
              // RL20: second byte is the low half
              ack_reg <= !sda;
              tx_reg <= hi_reg;
              hi_reg <= 8'h00;
            end
            if (scl_fall) begin
              bit_reg <= 4'd0;
              if (ack_reg) begin
                st_reg <= B_TX;
                SDA_OUT <= tx_reg[7];
                SDA_OE_N <= tx_reg[7];
              end else begin
                st_reg <= B_IGN;
              end
            end
          end
          B_IGN: SDA_OE_N <= 1'b1;
          default: st_reg <= B_IDLE;
        endcase
      end
      // RL9: soft reset restores defaults
      if (soft_rst_reg) begin
        cfg_reg <= `CFG_RESET;
        shunt_reg <= `REG_ZERO;
        bus_reg <= `REG_ZERO;
        power_reg <= `REG_ZERO;
        current_reg <= `REG_ZERO;
        cal_reg <= 15'h0000;
        mask_reg <= `REG_ZERO;
        limit_reg <= `REG_ZERO;
        alert_reg <= 1'b0;
      end
    end
  end
endmodule

/* File: test/bus_controller_model.sv */
// two-wire bus controller model: clock stands high between frames
`timescale 1ns/100ps
module bus_controller_model (
  // bus wires
  output logic scl,
  output logic sda_drv,
  input wire logic sda
);
  // half period, raised for code byte
  int hp = 400;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic start();
    #(hp/2) sda_drv = 1'b1;
    #(hp/2) scl = 1'b1;
    #hp sda_drv = 1'b0;
    #600 scl = 1'b0;
  endtask
  // stop, then bus idle
  task automatic stop();
    #(hp/2) sda_drv = 1'b0;
    #(hp/2) scl = 1'b1;
    #hp sda_drv = 1'b1;
    #hp;
  endtask
  // one bit, data moved only while clock low
  task automatic bit_io(input logic b, output logic r);
    #(hp/2) sda_drv = b;
    #(hp/2) scl = 1'b1;
    #(hp-50) r = sda;
    #50 scl = 1'b0;
  endtask
  // byte msb first plus acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] rq, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], rq[i]);
    bit_io(ack_in, ack);
  endtask
endmodule

/* File: test/target_checker_properties.sv */
// port-level checker for the monitor two-wire target
`timescale 1ns/100ps
module target_checker (
  // clock and reset
  input wire REF_CLK,
  input wire RST_N,
  // bus pins
  input wire SCL_IN,
  input wire SDA_IN,
  input wire SDA_OUT,
  input wire SDA_OE_N,
  // status outputs
  input wire ALERT_OE_N,
  input wire HS_MODE,
  input wire SHUNT_RANGE_SELECT
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  logic [7:0] hi_cnt; // cycles with bus clock high
  logic [7:0] lo_cnt; // cycles with data pulled low
  // run lengths, saturating
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      hi_cnt <= 8'h00;
      lo_cnt <= 8'h00;
    end else begin
      if (!SCL_IN) hi_cnt <= 8'h00;
      else if (hi_cnt != 8'hFF) hi_cnt <= hi_cnt + 8'h01;
      if (SDA_OE_N) lo_cnt <= 8'h00;
      else if (lo_cnt != 8'hFF) lo_cnt <= lo_cnt + 8'h01;
    end
  end
  property p_drive_low; !SDA_OE_N |-> !SDA_OUT; endproperty
  a_drive_low: assert property (p_drive_low) else $error("data driven high");
  property p_low_bound; lo_cnt < 8'h60; endproperty
  a_low_bound: assert property (p_low_bound) else $error("data held low too long");
  property p_clk_high; $changed(SDA_OE_N) |-> hi_cnt < 8'h06; endproperty
  a_clk_high: assert property (p_clk_high) else $error("data moved with clock high");
  property p_hs_no_ack; $rose(HS_MODE) |-> SDA_OE_N [*8]; endproperty
  a_hs_no_ack: assert property (p_hs_no_ack) else $error("fast code acknowledged");
  property p_hs_stop; HS_MODE && SCL_IN && $rose(SDA_IN) |-> ##[1:8] !HS_MODE; endproperty
  a_hs_stop: assert property (p_hs_stop) else $error("fast mode kept after stop");
  property p_hs_keep; $fell(HS_MODE) |-> SCL_IN && SDA_IN; endproperty
  a_hs_keep: assert property (p_hs_keep) else $error("fast mode left without stop");
  property p_rst_out; $rose(RST_N) |-> SDA_OE_N && ALERT_OE_N && !HS_MODE && !SHUNT_RANGE_SELECT; endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs wrong after reset");
  property p_range_ack; $changed(SHUNT_RANGE_SELECT) |-> ##[0:3] !SDA_OE_N; endproperty
  a_range_ack: assert property (p_range_ack) else $error("range moved outside a write");
endmodule
bind monitor_i2c_target target_checker chk_i (.REF_CLK(REF_CLK), .RST_N(RST_N), .SCL_IN(SCL_IN),
  .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N), .ALERT_OE_N(ALERT_OE_N), .HS_MODE(HS_MODE),
  .SHUNT_RANGE_SELECT(SHUNT_RANGE_SELECT));

/* File: test/testbench.sv */
// self-checking bench for the monitor two-wire target
`timescale 1ns/100ps
`include "monitor_defs.vh"
module testbench;
  localparam logic [15:0] MK = 16'hA5C3; // arbitrary value
  localparam logic [15:0] PT = 16'h3C5A; // arbitrary value
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] addr_sel = 2'h0;
  wire logic scl, sda_drv, sda;
  wire sda_out, sda_oe_n, alert_oe_n, hs_mode, range_sel, conv_busy;
  int err_count = 0;
  int compares = 0;
  logic [7:0] q;
  logic a;
  always #50 ref_clk = ~ref_clk;
  // open-drain data wire with pull-up
  assign sda = sda_drv & (sda_oe_n | sda_out);
  bus_controller_model ctl (.scl(scl), .sda_drv(sda_drv), .sda(sda));
  monitor_i2c_target #(.MAKER_CODE(MK), .PART_CODE(PT)) uut (.REF_CLK(ref_clk), .CE(1'b1), .RST_N(rst_n),
    .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .ADDRESS_SELECT_PIN(addr_sel),
    .ALERT_IN(alert_oe_n), .ALERT_OE_N(alert_oe_n), .HS_MODE(hs_mode), .SHUNT_RANGE_SELECT(range_sel),
    .CONV_BUSY(conv_busy));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] dev(input logic rw);
    return {`ADDR_BASE + {5'h00, addr_sel}, rw};
  endfunction
  task automatic wr(input logic [7:0] p, input logic [15:0] d);
    logic [7:0] b[4];
    b = '{dev(1'b0), p, d[15:8], d[7:0]};
    ctl.start();
    foreach (b[i]) begin
      ctl.xfer(b[i], 1'b1, q, a);
      chk({15'h0000, a}, 16'h0000);
    end
    ctl.stop();
  endtask
  // read a word, optionally setting the pointer first
  task automatic rdchk(input logic [7:0] p, input logic setp, input logic [15:0] e);
    logic [15:0] v;
    if (setp) begin
      ctl.start();
      ctl.xfer(dev(1'b0), 1'b1, q, a);
      ctl.xfer(p, 1'b1, q, a);
    end
    ctl.start();
    ctl.xfer(dev(1'b1), 1'b1, q, a);
    ctl.xfer(8'hFF, 1'b0, v[15:8], a);
    ctl.xfer(8'hFF, 1'b1, v[7:0], a);
    ctl.stop();
    chk(v, e);
  endtask
  task automatic t_regs();
    rdchk(`PTR_CONFIG, 1'b1, `CFG_RESET);
    for (int i = 1; i < 8; i++) rdchk(8'(i), 1'b1, `REG_ZERO);
    rdchk(`PTR_MAKER, 1'b1, MK);
    rdchk(`PTR_PART, 1'b1, PT);
  endtask
  task automatic t_cfg();
    wr(`PTR_CONFIG, 16'h1DB8);
    rdchk(`PTR_CONFIG, 1'b1, 16'h5DB8);
    chk({15'h0000, conv_busy}, 16'h0000);
    chk({15'h0000, range_sel}, 16'h0001);
    wr(`PTR_LIMIT, 16'hBEEF);
    rdchk(`PTR_LIMIT, 1'b1, 16'hBEEF);
    rdchk(`PTR_LIMIT, 1'b0, 16'hBEEF);
    wr(`PTR_SHUNT, 16'hFFFF);
    rdchk(`PTR_SHUNT, 1'b1, `REG_ZERO);
    wr(`PTR_CONFIG, 16'h8000);
    rdchk(`PTR_CONFIG, 1'b1, `CFG_RESET);
    rdchk(`PTR_LIMIT, 1'b1, `REG_ZERO);
    chk({15'h0000, range_sel}, 16'h0000);
  endtask
  task automatic t_gcall();
    wr(`PTR_LIMIT, 16'h55AA);
    ctl.start();
    ctl.xfer({`ADDR_GCALL, 1'b0}, 1'b1, q, a);
    ctl.xfer(`GCALL_RESET, 1'b1, q, a);
    ctl.stop();
    rdchk(`PTR_LIMIT, 1'b1, `REG_ZERO);
    wr(`PTR_MASK, 16'h0001);
    wr(`PTR_CONFIG, 16'h0001);
    for (int i = 0; i < 30000 && conv_busy !== 1'b0; i++) @(negedge ref_clk);
    ctl.start();
    ctl.xfer({`ADDR_GCALL, 1'b1}, 1'b1, q, a);
    ctl.stop();
    chk({15'h0000, a}, 16'h0001);
    for (int i = 0; i < 100 && conv_busy !== 1'b1; i++) @(negedge ref_clk);
    chk({15'h0000, conv_busy}, 16'h0001);
    for (int i = 0; i < 2000 && conv_busy !== 1'b0; i++) @(negedge ref_clk);
    chk({15'h0000, conv_busy}, 16'h0000);
    chk({15'h0000, alert_oe_n}, 16'h0000);
    ctl.start();
    ctl.xfer({`ADDR_ALERT, 1'b1}, 1'b1, q, a);
    chk({15'h0000, a}, 16'h0000);
    ctl.xfer(8'hFF, 1'b1, q, a);
    chk({8'h00, q}, {8'h00, dev(1'b0)});
    ctl.stop();
    chk({15'h0000, alert_oe_n}, 16'h0001);
  endtask
  task automatic t_hs();
    ctl.hp = 1250;
    ctl.start();
    ctl.xfer(8'h08, 1'b1, q, a);
    ctl.hp = 400;
    chk({15'h0000, a}, 16'h0001);
    ctl.start();
    ctl.xfer(dev(1'b0), 1'b1, q, a);
    chk({hs_mode, 14'h0000, a}, 16'h8000);
    ctl.stop();
    repeat (10) @(posedge ref_clk);
    chk({15'h0000, hs_mode}, 16'h0000);
  endtask
  task automatic t_addr();
    for (int c = 0; c < 5; c++) begin
      @(posedge ref_clk);
      #1 addr_sel = 2'(c);
      ctl.start();
      ctl.xfer(c < 4 ? dev(1'b0) : 8'h88, 1'b1, q, a);
      ctl.stop();
      chk({15'h0000, a}, c < 4 ? 16'h0000 : 16'h0001);
    end
    ctl.start();
    ctl.xfer({`ADDR_ALERT, 1'b1}, 1'b1, q, a);
    ctl.stop();
    chk({15'h0000, a}, 16'h0001);
  endtask
  task automatic summarize();
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #8000000;
    err_count++;
    summarize();
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    repeat (8) @(posedge ref_clk);
    t_regs();
    t_cfg();
    t_hs();
    t_addr();
    t_gcall();
    summarize();
  end
endmodule
